// File: serial_port.v
// full-duplex asynchronous serial port, 8-bit and 9-bit frames
// assumes: register port in the 8-bit special register space on ref_clk;
// serial_in is asynchronous and is synchronised here
`timescale 1ns/10ps
`include "serial_port_defs.vh"

module serial_port (
  input wire ref_clk,                // system clock, 250 MHz
  input wire rst,                    // synchronous reset, active high
  input wire [7:0] reg_addr,         // register address
  input wire reg_wr,                 // write strobe, one cycle
  input wire [7:0] reg_wdata,        // write data
  input wire reg_rd,                 // read strobe, one cycle
  output reg [7:0] reg_rdata,        // read data, valid cycle after reg_rd
  input wire timer_run,              // baud timer running
  input wire [7:0] baud_reload_value, // timer reload value
  input wire irq_enable,             // serial interrupt enable
  output wire serial_irq,            // interrupt request, level
  output wire tx_ready,              // transmit buffer has room
  input wire serial_in,              // receive pin, asynchronous
  output reg serial_out              // transmit pin
);

  // ----------------------------------------------------------------
  // control register bits
  // ----------------------------------------------------------------
  reg frame_length_select;
  reg address_filter_enable;
  reg receiver_enable;
  reg tx_ninth_bit;
  reg rx_ninth_bit;
  reg tx_done_flag;
  reg rx_done_flag;
  reg [7:0] rx_latch;
  wire [7:0] control_value;
  wire ctl_wr;
  wire buf_wr;
  reg tx_done_set;
  reg rx_done_set;

  assign ctl_wr = reg_wr && (reg_addr == `ADDR_SERIAL_CONTROL);
  assign buf_wr = reg_wr && (reg_addr == `ADDR_DATA_BUFFER);

  assign control_value = {frame_length_select, 1'b1, address_filter_enable,
    receiver_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};

  assign serial_irq = irq_enable && (tx_done_flag || rx_done_flag);

  // ----------------------------------------------------------------
  // bit timing: two timers sharing one reload value
  // ----------------------------------------------------------------
  wire tx_ovf;
  wire rx_ovf;
  reg rx_force;
  reg tx_half;

  baud_timer tx_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(timer_run),
    .force_reload(1'b0),
    .reload_value(baud_reload_value),
    .overflow(tx_ovf)
  );

  baud_timer rx_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(timer_run),
    .force_reload(rx_force),
    .reload_value(baud_reload_value),
    .overflow(rx_ovf)
  );

  wire tx_tick;
  assign tx_tick = tx_ovf && tx_half;
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_half <= 1'b0;
    end else if (tx_ovf) begin
      tx_half <= ~tx_half;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer: a stall by the shifter loses no byte written while tx_ready is high
  // ----------------------------------------------------------------
  wire buf_valid;
  wire [7:0] buf_data;
  reg buf_take;

  two_entry_buffer tx_buffer (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(buf_wr),
    .in_ready(tx_ready),
    .in_data(reg_wdata),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  localparam TX_IDLE = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_NINTH = 3'd3;
  localparam TX_STOP = 3'd4;

  reg [2:0] tx_state;
  reg [7:0] tx_shift;
  reg [3:0] tx_count;
  reg tx_ninth_latched;

  always @* begin
    buf_take = (tx_state == TX_IDLE) && tx_tick && buf_valid;
  end

  // shifter steps once per bit tick; start aligns to the next tick
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_count <= 4'h0;
      tx_ninth_latched <= 1'b0;
      serial_out <= 1'b1;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (tx_tick) begin
        case (tx_state)
          TX_IDLE: begin
            serial_out <= 1'b1;
            if (buf_valid) begin
              serial_out <= 1'b0;
              tx_shift <= buf_data;
              tx_ninth_latched <= tx_ninth_bit;
              tx_count <= 4'h0;
              tx_state <= TX_START;
            end
          end
          TX_START, TX_DATA: begin
            serial_out <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_count <= tx_count + 4'h1;
            tx_state <= TX_DATA;
            if (tx_count == `DATA_BITS) begin
              if (frame_length_select) begin
                serial_out <= tx_ninth_latched;
                tx_state <= TX_NINTH;
              end else begin
                serial_out <= 1'b1;
                tx_done_set <= 1'b1;
                tx_state <= TX_STOP;
              end
            end
          end
          TX_NINTH: begin
            serial_out <= 1'b1;
            tx_done_set <= 1'b1;
            tx_state <= TX_STOP;
          end
          TX_STOP: begin
            serial_out <= 1'b1;
            tx_state <= TX_IDLE;
          end
          default: begin
            serial_out <= 1'b1;
            tx_state <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive pin: three flops, change taken when last two agree
  // ----------------------------------------------------------------
  reg [2:0] rx_sync;
  reg rx_level;
  reg rx_level_prev;

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_sync <= 3'b111;
      rx_level <= 1'b1;
      rx_level_prev <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], serial_in};
      if (rx_sync[2] == rx_sync[1]) begin
        rx_level <= rx_sync[1];
      end
      rx_level_prev <= rx_level;
    end
  end

  // ----------------------------------------------------------------
  // receiver: reload at start edge, first overflow is mid start bit,
  // then every second overflow is the centre of the next bit
  // ----------------------------------------------------------------
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS = 2'd2;
  localparam RX_STOP = 2'd3;

  reg [1:0] rx_state;
  reg rx_phase;
  reg [3:0] rx_count;
  reg [8:0] rx_shift;
  reg [7:0] next_rx_latch;
  reg next_rx_ninth;
  reg rx_accept;
  wire rx_sample;
  wire rx_fall;

  assign rx_sample = rx_ovf && rx_phase;
  assign rx_fall = rx_level_prev && !rx_level;

  // acceptance check on the received ninth bit, or on the sampled stop level in 8-bit mode
  always @* begin
    next_rx_latch = rx_shift[7:0];
    next_rx_ninth = frame_length_select ? rx_shift[8] : rx_level;
    rx_accept = !rx_done_flag && (!address_filter_enable || next_rx_ninth);
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_phase <= 1'b0;
      rx_count <= 4'h0;
      rx_shift <= 9'h000;
      rx_force <= 1'b0;
      rx_latch <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_done_set <= 1'b0;
    end else begin
      rx_force <= 1'b0;
      rx_done_set <= 1'b0;
      // software may write the ninth bit; a hardware load below wins
      if (ctl_wr) begin
        rx_ninth_bit <= reg_wdata[`BIT_RX_NINTH];
      end
      case (rx_state)
        RX_IDLE: begin
          if (receiver_enable && rx_fall) begin
            rx_force <= 1'b1;
            rx_phase <= 1'b0;
            rx_count <= 4'h0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          // an overflow from before the forced reload is stale: skip it
          if (rx_ovf && !rx_force) begin
            // a glitch shorter than half a bit is not a start
            rx_state <= rx_level ? RX_IDLE : RX_BITS;
            rx_phase <= 1'b0;
          end
        end
        RX_BITS: begin
          if (rx_ovf) begin
            rx_phase <= ~rx_phase;
          end
          if (rx_sample) begin
            rx_shift <= frame_length_select ? {rx_level, rx_shift[8:1]}
              : {1'b0, rx_level, rx_shift[7:1]};
            rx_count <= rx_count + 4'h1;
            if (rx_count == (frame_length_select ? `DATA_BITS : 4'h7)) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_ovf) begin
            rx_phase <= ~rx_phase;
          end
          if (rx_sample) begin
            rx_state <= RX_IDLE;
            if (rx_accept) begin
              rx_latch <= next_rx_latch;
              rx_ninth_bit <= next_rx_ninth;
              rx_done_set <= 1'b1;
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control register: software bits and the two sticky flags
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      frame_length_select <= `FRAME_LENGTH_RESET;
      address_filter_enable <= 1'b0;
      receiver_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      if (ctl_wr) begin
        frame_length_select <= reg_wdata[`BIT_FRAME_LENGTH_SELECT];
        address_filter_enable <= reg_wdata[`BIT_ADDRESS_FILTER_ENABLE];
        receiver_enable <= reg_wdata[`BIT_RECEIVER_ENABLE];
        tx_ninth_bit <= reg_wdata[`BIT_TX_NINTH];
      end
      tx_done_flag <= tx_done_set ||
        (ctl_wr ? reg_wdata[`BIT_TX_DONE] : tx_done_flag);
      rx_done_flag <= rx_done_set ||
        (ctl_wr ? reg_wdata[`BIT_RX_DONE] : rx_done_flag);
    end
  end

  // ----------------------------------------------------------------
  // read port, registered; reads have no side effects
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_SERIAL_CONTROL: reg_rdata <= control_value;
        `ADDR_DATA_BUFFER: reg_rdata <= rx_latch;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // serial_port

// File: serial_port_defs.vh
// constants for the 8/9-bit asynchronous serial port
// assumes: included by every design file of the port except the two-entry buffer, by bare name
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// ----------------------------------------------------------------
// register map (8-bit special register space)
// ----------------------------------------------------------------
`define ADDR_SERIAL_CONTROL 8'h98
`define ADDR_DATA_BUFFER 8'h99
`define SERIAL_CONTROL_RESET 8'h40
`define FRAME_LENGTH_RESET 1'b0

// ----------------------------------------------------------------
// serial_control field positions
// ----------------------------------------------------------------
`define BIT_FRAME_LENGTH_SELECT 7
`define BIT_UNUSED_ONE 6
`define BIT_ADDRESS_FILTER_ENABLE 5
`define BIT_RECEIVER_ENABLE 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TIMER_TOP 8'hff
`define DATA_BITS 4'h8

`endif

// File: baud_timer.v
// 8-bit auto-reload timer giving one-cycle overflow pulses
// assumes: run and force_reload come from logic on ref_clk
`timescale 1ns/10ps
`include "serial_port_defs.vh"

module baud_timer (
  input wire ref_clk,            // system clock
  input wire rst,                // synchronous reset, active high
  input wire run,                // count enable (timer running)
  input wire force_reload,       // restart the count from reload
  input wire [7:0] reload_value, // auto-reload value
  output reg overflow            // one-cycle pulse on wrap
);

  reg [7:0] count;

  // ----------------------------------------------------------------
  // counter: counts up, wraps to the reload value
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      count <= 8'h00;
      overflow <= 1'b0;
    end else if (force_reload) begin
      count <= reload_value;
      overflow <= 1'b0;
    end else if (run && count == `TIMER_TOP) begin
      count <= reload_value;
      overflow <= 1'b1;
    end else begin
      count <= run ? count + 8'h01 : count;
      overflow <= 1'b0;
    end
  end

endmodule // baud_timer

// File: two_entry_buffer.v
// two-entry buffer with valid/ready on both sides
// assumes: both sides on ref_clk; a word moves when valid and ready are high
`timescale 1ns/10ps

module two_entry_buffer (
  input wire ref_clk,        // system clock
  input wire rst,            // synchronous reset, active high
  input wire in_valid,       // word offered
  output wire in_ready,      // room for a word
  input wire [7:0] in_data,  // offered word
  output wire out_valid,     // word available
  input wire out_ready,      // drain side takes the word
  output reg [7:0] out_data  // oldest word
);

  reg [7:0] second;
  reg [1:0] fill;

  assign in_ready = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);

  // ----------------------------------------------------------------
  // storage: head register plus one behind it
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      fill <= 2'd0;
      out_data <= 8'h00;
      second <= 8'h00;
    end else begin
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10: begin
          if (fill == 2'd0) begin
            out_data <= in_data;
          end else begin
            second <= in_data;
          end
          fill <= fill + 2'd1;
        end
        2'b01: begin
          out_data <= second;
          fill <= fill - 2'd1;
        end
        2'b11: begin
          // simultaneous pop and push keeps the fill level
          if (fill == 2'd1) begin
            out_data <= in_data;
          end else begin
            out_data <= second;
            second <= in_data;
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end

endmodule // two_entry_buffer

// File: serial_port_assertions.sv
// checker for the serial port's register, interrupt and line behaviour
// assumes: bound to serial_port, one clock, reset synchronous active high
`timescale 1ns/10ps
module serial_port_assertions (
  input wire ref_clk, // system clock
  input wire rst, // synchronous reset
  input wire [7:0] reg_addr, // register address
  input wire reg_wr, // write strobe
  input wire [7:0] reg_wdata, // write data
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire timer_run, // baud timer running
  input wire [7:0] baud_reload_value, // timer reload
  input wire irq_enable, // interrupt enable
  input wire serial_irq, // interrupt request
  input wire tx_ready, // transmit room
  input wire serial_in, // receive pin
  input wire serial_out // transmit pin
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // control writes decoded once for several properties
  wire ctrl_wr = reg_wr && reg_addr == 8'h98;
  property p_reset_idle;
    @(posedge ref_clk) rst |=> serial_out && tx_ready && !serial_irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  property p_irq_gate;
    @(posedge ref_clk) disable iff (rst) !irq_enable |-> !serial_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  property p_irq_set;
    @(posedge ref_clk) disable iff (rst)
      ctrl_wr && reg_wdata[1:0] != 2'b00 |=> serial_irq || !irq_enable;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("flag set gave no irq");
  // hardware must never drop a done flag on its own
  property p_flag_hold;
    @(posedge ref_clk) disable iff (rst) serial_irq && !ctrl_wr |=> serial_irq || !irq_enable;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
  property p_bit6;
    @(posedge ref_clk) disable iff (rst) reg_rd && reg_addr == 8'h98 |=> reg_rdata[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("control bit 6 read 0");
  property p_unmapped;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr != 8'h98 && reg_addr != 8'h99 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (rst) !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // a start bit is at least eight cycles for any period of five or more
  property p_start_len;
    @(posedge ref_clk) disable iff (rst)
      $fell(serial_out) && baud_reload_value <= 8'hfb |-> !serial_out [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_tx_start;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == 8'h99 && tx_ready && timer_run && baud_reload_value >= 8'hf0
      |-> ##[1:1000] !serial_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write sent nothing");
endmodule // serial_port_assertions

bind serial_port serial_port_assertions serial_port_assertions_inst (.ref_clk(ref_clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_run(timer_run),
  .baud_reload_value(baud_reload_value), .irq_enable(irq_enable),
  .serial_irq(serial_irq), .tx_ready(tx_ready), .serial_in(serial_in),
  .serial_out(serial_out));

// File: far_node.sv
// behavioural far serial node: sends frames and collects received ones
// assumes: BIT matches the port's bit period in ref_clk cycles
`timescale 1ns/10ps
module far_node #(parameter BIT = 32) (
  input wire ref_clk, // system clock
  input wire line_in, // from the port's transmit pin
  output reg line_out // to the port's receive pin
);
  reg nine_mode; // expect a ninth bit on receive
  reg [7:0] got_q [$];
  reg got9_q [$];
  integer stop_errs;
  // line idles high from time zero
  initial begin
    line_out = 1'b1;
    nine_mode = 1'b0;
    stop_errs = 0;
  end
  // ----------------------------------------------------------------
  // transmit and receive
  // ----------------------------------------------------------------
  // lsb-first frames; stop level chosen by caller
  task send_frame(input [7:0] d, input nine, input b9, input stp);
    reg [10:0] v;
    integer i;
    begin
      v = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
      @(posedge ref_clk);
      for (i = 0; i < (nine ? 11 : 10); i = i + 1) begin
        #1 line_out = v[i];
        repeat (BIT) @(posedge ref_clk);
      end
      #1 line_out = 1'b1;
      repeat (BIT) @(posedge ref_clk);
      #1;
    end
  endtask
  // sample each bit at its centre, from the falling start edge
  always begin : rx_loop
    reg [8:0] sh;
    integer k;
    @(negedge line_in);
    sh = 9'h000;
    repeat (BIT / 2) @(posedge ref_clk);
    for (k = 0; k < (nine_mode ? 9 : 8); k = k + 1) begin
      repeat (BIT) @(posedge ref_clk);
      sh[k] = line_in;
    end
    repeat (BIT) @(posedge ref_clk);
    if (line_in !== 1'b1)
      stop_errs = stop_errs + 1;
    got_q.push_back(sh[7:0]);
    got9_q.push_back(sh[8]);
  end
endmodule // far_node

// File: serial_port_tb.sv
// self-checking bench for the 8/9-bit serial port
// assumes: far_node and the bound checker are compiled before this file
`timescale 1ns/10ps
module serial_port_tb;
  reg ref_clk, rst, reg_wr, reg_rd, timer_run, irq_enable;
  reg [7:0] reg_addr, reg_wdata, baud_reload_value, last_rx, r;
  reg last_rb8;
  wire [7:0] reg_rdata;
  wire serial_irq, tx_ready, serial_in, serial_out;
  integer failures, check_count;
  serial_port serial_port_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_run(timer_run), .baud_reload_value(baud_reload_value),
    .irq_enable(irq_enable), .serial_irq(serial_irq), .tx_ready(tx_ready),
    .serial_in(serial_in), .serial_out(serial_out));
  // reload 0xf0 gives 16-cycle overflows, so 32-cycle bits
  far_node #(.BIT(32)) far_node_inst (.ref_clk(ref_clk), .line_in(serial_out),
    .line_out(serial_in));
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // bus and compare tasks, all entered 1 ns after a rising edge
  // ----------------------------------------------------------------
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      // one idle edge so a following call never re-raises the strobe at once
      @(posedge ref_clk);
      #1;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      // read data stands from the edge after the strobe
      @(posedge ref_clk);
      #1 d = reg_rdata;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      rd(8'h98, r);
      check(r, 8'h40);
      rd(8'h12, r);
      check(r, 8'h00);
      wr(8'h98, 8'hff);
      rd(8'h98, r);
      check(r, 8'hff);
      repeat (50) @(posedge ref_clk);
      #1 check({7'h00, serial_irq}, 8'h01);
      irq_enable = 1'b0;
      #4 check({7'h00, serial_irq}, 8'h00);
      irq_enable = 1'b1;
      wr(8'h98, 8'h00);
      rd(8'h98, r);
      check(r, 8'h40);
      check({7'h00, serial_irq}, 8'h00);
      $display("test regs done");
    end
  endtask
  // fill the transmit path until refused, then one more write that must vanish
  task t_tx(input mode);
    integer n, i;
    begin
      far_node_inst.nine_mode = mode;
      // tx_ninth_bit 0 in 8-bit mode; the 8-bit frame never sends it, so the stop stays high
      wr(8'h98, {mode, 3'b000, mode, 3'b000});
      n = 0;
      while (tx_ready === 1'b1 && n < 6) begin
        wr(8'h99, 8'h5a + n[7:0]);
        n = n + 1;
      end
      check({7'h00, n < 6}, 8'h01);
      wr(8'h99, 8'hee);
      repeat (400 * n + 400) @(posedge ref_clk);
      #1 check(far_node_inst.got_q.size(), n[7:0]);
      for (i = 0; i < n; i = i + 1) begin
        check(far_node_inst.got_q.pop_front(), 8'h5a + i[7:0]);
        check(far_node_inst.got9_q.pop_front(), {7'h00, mode});
      end
      check(far_node_inst.stop_errs, 8'h00);
      rd(8'h98, r);
      check(r[1], 1'b1);
      $display("test tx mode %0d done", mode);
    end
  endtask
  // one received frame under a given control setting
  task rx_case(input [7:0] ctrl, input nine, input [7:0] d, input b9, input stp, input acc);
    begin
      wr(8'h98, ctrl);
      last_rb8 = ctrl[2];
      far_node_inst.send_frame(d, nine, b9, stp);
      if (acc) begin
        last_rx = d;
        last_rb8 = nine ? b9 : stp;
      end
      rd(8'h98, r);
      check(r[0], acc | ctrl[0]);
      check(r[2], last_rb8);
      rd(8'h99, r);
      check(r, last_rx);
      rd(8'h98, r);
      check(r[0], acc | ctrl[0]);
      $display("test rx %h done", d);
    end
  endtask
  // stimulus and run order
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    timer_run = 1'b1;
    baud_reload_value = 8'hf0;
    irq_enable = 1'b1;
    last_rx = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_regs;
    t_tx(1'b0);
    t_tx(1'b1);
    rx_case(8'h10, 1'b0, 8'h96, 1'b0, 1'b1, 1'b1);
    rx_case(8'h10, 1'b0, 8'h66, 1'b0, 1'b0, 1'b1);
    rx_case(8'h11, 1'b0, 8'h33, 1'b0, 1'b1, 1'b0);
    rx_case(8'h30, 1'b0, 8'h44, 1'b0, 1'b0, 1'b0);
    rx_case(8'h30, 1'b0, 8'h55, 1'b0, 1'b1, 1'b1);
    rx_case(8'h00, 1'b0, 8'h77, 1'b0, 1'b1, 1'b0);
    rx_case(8'hb0, 1'b1, 8'h21, 1'b0, 1'b1, 1'b0);
    rx_case(8'hb0, 1'b1, 8'h22, 1'b1, 1'b0, 1'b1);
    rx_case(8'h90, 1'b1, 8'h23, 1'b0, 1'b1, 1'b1);
    close_out;
  end
  // watchdog: the tests need well under 20000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures = failures + 1;
    close_out;
  end
endmodule // serial_port_tb
